// file: pkg/pld_pkg.sv
package pld_pkg;

	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int NUM_CELLS      = 8;  // output macrocells
	localparam int NUM_INPUTS     = 8;  // dedicated input pins
	localparam int TERMS_PER_CELL = 8;  // product terms per macrocell
	localparam int NUM_TERMS      = 64; // all product terms
	localparam int NUM_COLS       = 16; // array input columns
	localparam int ROW_WIDTH      = 32; // true and complement fuses per term
	localparam int SIG_WIDTH      = 64; // user signature bits
	localparam int ADDR_WIDTH     = 7;  // configuration port address
	localparam int DATA_WIDTH     = 32; // configuration port data
	localparam int PD_INPUT_IDX   = 2;  // input column shared with the hold pin

	// ----------------------------------------
	// configuration port map (word indices)
	// ----------------------------------------
	localparam logic [6:0] ADDR_ARCH   = 7'h40; // mode, hold enable, polarity, roles
	localparam logic [6:0] ADDR_SECURE = 7'h41; // security fuse
	localparam logic [6:0] ADDR_SIG_LO = 7'h42; // signature bits 31..0
	localparam logic [6:0] ADDR_SIG_HI = 7'h43; // signature bits 63..32
	localparam logic [6:0] ADDR_STATUS = 7'h44; // live cell state

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int ARCH_MODE_LSB = 0;
	localparam int ARCH_PD_BIT   = 2;
	localparam int ARCH_POL_LSB  = 8;
	localparam int ARCH_ROLE_LSB = 16;
	localparam int STAT_Q_LSB    = 0;
	localparam int STAT_OUT_LSB  = 8;
	localparam int STAT_OE_LSB   = 16;
	localparam int STAT_HOLD_BIT = 24;
	localparam int STAT_SEC_BIT  = 25;
	localparam logic [31:0] ARCH_RESET = 32'hffff_0000;
	localparam logic [31:0] ROW_RESET  = 32'hffff_ffff;
	localparam logic [63:0] SIG_RESET  = 64'h0000_0000_0000_0000;

	// ----------------------------------------
	// modes and roles
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_REGISTERED = 2'b00,
		MODE_COMPLEX    = 2'b01,
		MODE_SIMPLE     = 2'b10
	} arch_mode_t;

	typedef enum logic [1:0] {
		CELL_REGISTERED = 2'b00,
		CELL_COMB_IO    = 2'b01,
		CELL_COMB_OUT   = 2'b10,
		CELL_INPUT      = 2'b11
	} cell_role_t;

endpackage

// file: rtl/fuse_store.sv
`timescale 1ns/1ps
`default_nettype none
module fuse_store
	import pld_pkg::*;
#(
	parameter int ROWS  = NUM_TERMS,
	parameter int WIDTH = ROW_WIDTH
) (
	// system
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	// write port
	input  wire logic                  wr_en,
	input  wire logic [5:0]            wr_row,
	input  wire logic [WIDTH-1:0]      wr_data,
	// all rows, straight from the cells
	output logic      [ROWS*WIDTH-1:0] rows_flat
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// reset leaves every term with both literals of each column: off
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int r = 0; r < ROWS; r++) begin
				rows_flat[r*WIDTH +: WIDTH] <= ROW_RESET;
			end
		end else if (wr_en) begin
			rows_flat[wr_row*WIDTH +: WIDTH] <= wr_data;
		end
	end

endmodule
`default_nettype wire

// file: rtl/macro_cell.sv
`timescale 1ns/1ps
`default_nettype none
module macro_cell
	import pld_pkg::*;
#(
	parameter int TERMS = TERMS_PER_CELL
) (
	// system
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// array side
	input  wire logic [TERMS-1:0] terms,
	input  wire logic [1:0]       mode,
	input  wire logic [1:0]       role,
	input  wire logic             polar,
	input  wire logic             center,
	input  wire logic             outer,
	// common controls
	input  wire logic             clk_edge,
	input  wire logic             oe_pin_n,
	input  wire logic             hold,
	// results
	output logic                  q,
	output logic                  pin_out,
	output logic                  pin_oe
);

	logic sum_all;  // sum of all terms
	logic sum_rest; // sum without the enable term
	logic out_next; // combinatorial pin value
	logic oe_next;  // driver enable
	logic is_reg;   // cell behaves as a register

	// ----------------------------------------
	// per mode role decode
	// ----------------------------------------
	always_comb begin
		sum_all  = (|terms) ^ polar;
		sum_rest = (|terms[TERMS-1:1]) ^ polar;
		out_next = sum_rest;
		oe_next  = 1'b0;
		is_reg   = 1'b0;
		unique case (arch_mode_t'(mode))
			MODE_REGISTERED: begin
				unique case (cell_role_t'(role))
					CELL_REGISTERED: begin
						is_reg  = 1'b1;
						oe_next = ~oe_pin_n;
					end
					CELL_COMB_IO:  oe_next = terms[0];
					CELL_COMB_OUT: oe_next = 1'b1;
					CELL_INPUT:    oe_next = 1'b0;
				endcase
			end
			MODE_COMPLEX: begin
				if (cell_role_t'(role) == CELL_INPUT && !outer) begin
					oe_next = 1'b0;
				end else begin
					oe_next = terms[0];
				end
			end
			MODE_SIMPLE: begin
				out_next = sum_all;
				oe_next  = center || cell_role_t'(role) != CELL_INPUT;
			end
			default: oe_next = 1'b0;
		endcase
	end

	// ----------------------------------------
	// cell register
	// ----------------------------------------
	// power-up clears register low
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q <= 1'b0;
		end else if (is_reg && clk_edge && !hold) begin
			q <= sum_all;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// frozen while holding
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pin_out <= 1'b1;
			pin_oe  <= 1'b0;
		end else if (!hold) begin
			pin_oe <= oe_next;
			if (is_reg) begin
				pin_out <= clk_edge ? ~sum_all : ~q;
			end else begin
				pin_out <= out_next;
			end
		end
	end

endmodule
`default_nettype wire

// file: rtl/pld_array.sv
`timescale 1ns/1ps
`default_nettype none
module pld_array
	import pld_pkg::*;
(
	// system
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	// configuration port
	input  wire logic [ADDR_WIDTH-1:0] cfg_addr,
	input  wire logic [DATA_WIDTH-1:0] cfg_wdata,
	input  wire logic                  cfg_write,
	input  wire logic                  cfg_read,
	output logic      [DATA_WIDTH-1:0] cfg_rdata,
	// common pins
	input  wire logic                  clk_pin,
	input  wire logic                  oe_pin_n,
	input  wire logic [NUM_INPUTS-1:0] in_pins,
	// macrocell pins
	input  wire logic [NUM_CELLS-1:0]  io_in,
	output logic      [NUM_CELLS-1:0]  io_out,
	output logic      [NUM_CELLS-1:0]  io_oe
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// product term: and of all connected literals
	function automatic logic term_eval(
		input logic [ROW_WIDTH-1:0] row,
		input logic [NUM_COLS-1:0]  cols
	);
		logic [ROW_WIDTH-1:0] lit;
		lit = {~cols, cols};
		return &(lit | ~row);
	endfunction

	// role field of one cell
	function automatic cell_role_t role_of(
		input logic [31:0] arch,
		input int          k
	);
		return cell_role_t'(arch[ARCH_ROLE_LSB + 2*k +: 2]);
	endfunction

	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	logic [31:0]                 output_cell_configuration_reg; // arch word
	logic                        secure_reg;   // security fuse
	logic [SIG_WIDTH-1:0]        sig_reg;      // user signature
	logic [DATA_WIDTH-1:0]       rdata_next;   // read mux
	logic [NUM_TERMS*ROW_WIDTH-1:0] rows_flat; // all fuse rows
	logic                        row_write;    // fuse row write
	logic [1:0]                  mode;         // active mode code
	logic                        pd_enable;    // hold option selected
	logic [NUM_CELLS-1:0]        polar;        // output polarity
	logic [NUM_CELLS-1:0]        in_mask;      // cells acting as inputs

	assign mode      = output_cell_configuration_reg[ARCH_MODE_LSB +: 2];
	assign pd_enable = output_cell_configuration_reg[ARCH_PD_BIT];
	assign polar     = output_cell_configuration_reg[ARCH_POL_LSB +: NUM_CELLS];
	assign row_write = cfg_write && !cfg_addr[6];

	// ----------------------------------------
	// array state
	// ----------------------------------------
	logic                 low_power_hold_pin; // shared with pin 4
	logic                 hold;               // hold in force
	logic                 clk_prev_reg;       // last sampled clock pin
	logic                 clk_edge;           // rising common clock
	logic [NUM_COLS-1:0]  cols;               // array inputs
	logic [NUM_TERMS-1:0] terms;              // product terms
	logic [NUM_CELLS-1:0] cell_q;             // macrocell registers

	assign low_power_hold_pin = in_pins[PD_INPUT_IDX];

	// ----------------------------------------
	// fuse rows
	// ----------------------------------------
	fuse_store #(
		.ROWS  (NUM_TERMS),
		.WIDTH (ROW_WIDTH)
	) u_fuse (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.wr_en     (row_write),
		.wr_row    (cfg_addr[5:0]),
		.wr_data   (cfg_wdata),
		.rows_flat (rows_flat)
	);

	// ----------------------------------------
	// configuration writes
	// ----------------------------------------
	// mode fixed by the arch word
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			output_cell_configuration_reg <= ARCH_RESET;
		end else if (cfg_write && cfg_addr == ADDR_ARCH) begin
			output_cell_configuration_reg <= cfg_wdata;
		end
	end

	// security fuse only ever sets
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			secure_reg <= 1'b0;
		end else if (cfg_write && cfg_addr == ADDR_SECURE && cfg_wdata[0]) begin
			secure_reg <= 1'b1;
		end
	end

	// signature words
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sig_reg <= SIG_RESET;
		end else if (cfg_write && cfg_addr == ADDR_SIG_LO) begin
			sig_reg[31:0] <= cfg_wdata;
		end else if (cfg_write && cfg_addr == ADDR_SIG_HI) begin
			sig_reg[63:32] <= cfg_wdata;
		end
	end

	// ----------------------------------------
	// configuration reads
	// ----------------------------------------
	always_comb begin
		rdata_next = '0;
		if (!cfg_addr[6]) begin
			// fuse rows hidden once secured
			if (!secure_reg) begin
				rdata_next = rows_flat[cfg_addr[5:0]*ROW_WIDTH +: ROW_WIDTH];
			end
		end else begin
			unique case (cfg_addr)
				ADDR_ARCH:   rdata_next = secure_reg ? '0 : output_cell_configuration_reg;
				ADDR_SECURE: rdata_next = {31'h0000_0000, secure_reg};
				ADDR_SIG_LO: rdata_next = sig_reg[31:0];
				ADDR_SIG_HI: rdata_next = sig_reg[63:32];
				ADDR_STATUS: begin
					rdata_next[STAT_Q_LSB +: NUM_CELLS]   = cell_q;
					rdata_next[STAT_OUT_LSB +: NUM_CELLS] = io_out;
					rdata_next[STAT_OE_LSB +: NUM_CELLS]  = io_oe;
					rdata_next[STAT_HOLD_BIT]             = hold;
					rdata_next[STAT_SEC_BIT]              = secure_reg;
				end
				default:     rdata_next = '0;
			endcase
		end
	end

	// read data valid the cycle after the strobe only
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cfg_rdata <= '0;
		end else if (cfg_read) begin
			cfg_rdata <= rdata_next;
		end else begin
			cfg_rdata <= '0;
		end
	end

	// ----------------------------------------
	// hold and common clock
	// ----------------------------------------
	// hold pin high with option on
	assign hold = pd_enable && low_power_hold_pin;

	// clock level tracked always, through hold and reset alike, so that
	// neither leaving hold nor leaving reset with the pin high looks like an edge
	always_ff @(posedge ref_clk) begin
		clk_prev_reg <= clk_pin;
	end

	// pin 1 clocks registered mode only
	assign clk_edge = clk_pin && !clk_prev_reg && !hold
		&& arch_mode_t'(mode) == MODE_REGISTERED;

	// ----------------------------------------
	// array input columns
	// ----------------------------------------
	always_comb begin
		cols = '0;
		cols[NUM_INPUTS-1:0] = in_pins;
		if (pd_enable) begin
			cols[PD_INPUT_IDX] = 1'b0;
		end
		unique case (arch_mode_t'(mode))
			MODE_REGISTERED: begin
				// registered cells feed back their state
				for (int k = 0; k < NUM_CELLS; k++) begin
					cols[NUM_INPUTS + k] = (role_of(output_cell_configuration_reg, k)
						== CELL_REGISTERED) ? cell_q[k] : io_in[k];
				end
			end
			MODE_COMPLEX: begin
				// pins 11 and 1 on outer paths
				cols[NUM_INPUTS]     = oe_pin_n;
				cols[NUM_COLS-1]     = clk_pin;
				cols[NUM_COLS-2:NUM_INPUTS+1] = io_in[NUM_CELLS-2:1];
			end
			MODE_SIMPLE: begin
				// pins 1 and 11 as inputs
				cols[NUM_INPUTS]     = oe_pin_n;
				cols[NUM_COLS-1]     = clk_pin;
				cols[NUM_INPUTS+3:NUM_INPUTS+1] = io_in[2:0];
				cols[NUM_INPUTS+6:NUM_INPUTS+4] = io_in[7:5];
			end
			default: cols[NUM_COLS-1:NUM_INPUTS] = '0;
		endcase
	end

	// cells acting as inputs in the active mode
	always_comb begin
		in_mask = '0;
		for (int k = 0; k < NUM_CELLS; k++) begin
			if (role_of(output_cell_configuration_reg, k) == CELL_INPUT) begin
				in_mask[k] = 1'b1;
			end
		end
		if (arch_mode_t'(mode) == MODE_COMPLEX) begin
			in_mask[0] = 1'b0;
			in_mask[NUM_CELLS-1] = 1'b0;
		end
		if (arch_mode_t'(mode) == MODE_SIMPLE) begin
			in_mask[4:3] = 2'b00;
		end
	end

	// ----------------------------------------
	// product terms and macrocells
	// ----------------------------------------
	// eight macrocells of eight terms
	for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
		assign terms[t] = term_eval(rows_flat[t*ROW_WIDTH +: ROW_WIDTH], cols);
	end

	for (genvar k = 0; k < NUM_CELLS; k++) begin : g_cell
		macro_cell #(
			.TERMS (TERMS_PER_CELL)
		) u_cell (
			.ref_clk  (ref_clk),
			.resetn   (resetn),
			.terms    (terms[k*TERMS_PER_CELL +: TERMS_PER_CELL]),
			.mode     (mode),
			.role     (output_cell_configuration_reg[ARCH_ROLE_LSB + 2*k +: 2]),
			.polar    (polar[k]),
			.center   (k == 3 || k == 4),
			.outer    (k == 0 || k == NUM_CELLS-1),
			.clk_edge (clk_edge),
			.oe_pin_n (oe_pin_n),
			.hold     (hold),
			.q        (cell_q[k]),
			.pin_out  (io_out[k]),
			.pin_oe   (io_oe[k])
		);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_input_cell_off: assert property (
		!hold |=> (io_oe & $past(in_mask)) == '0
	) else $error("input cell drives its pin");

	a_center_driven: assert property (
		(arch_mode_t'(mode) == MODE_SIMPLE && !hold) |=> io_oe[4:3] == 2'b11
	) else $error("center cell not driven in simple mode");

	a_reg_capture: assert property (
		(clk_edge && role_of(output_cell_configuration_reg, 0) == CELL_REGISTERED)
		|=> cell_q[0] == $past((|terms[7:0]) ^ polar[0]) && io_out[0] == !cell_q[0]
	) else $error("register did not capture eight term sum");

	a_reg_enable_pin: assert property (
		(arch_mode_t'(mode) == MODE_REGISTERED && !hold
		&& role_of(output_cell_configuration_reg, 0) == CELL_REGISTERED)
		|=> io_oe[0] == !$past(oe_pin_n)
	) else $error("registered enable not from common pin");

	a_hold_frozen: assert property (
		hold |=> $stable(io_out) && $stable(io_oe) && $stable(cell_q)
	) else $error("state moved during hold");

	a_hold_column: assert property (
		pd_enable |-> !cols[PD_INPUT_IDX]
	) else $error("shared input reaches array with hold option");

	a_no_edge_still: assert property (
		!clk_edge |=> $stable(cell_q)
	) else $error("register changed without clock edge");

	a_complex_feed: assert property (
		arch_mode_t'(mode) == MODE_COMPLEX |-> cols[NUM_COLS-1] == clk_pin
		&& cols[NUM_INPUTS] == oe_pin_n
	) else $error("complex mode pins 1 and 11 misrouted");

	a_complex_seven: assert property (
		(arch_mode_t'(mode) == MODE_COMPLEX && !hold)
		|=> io_oe[1] == $past(terms[8]) && io_out[1] == $past((|terms[15:9]) ^ polar[1])
	) else $error("complex cell term split wrong");

	a_sig_read: assert property (
		(cfg_read && cfg_addr == ADDR_SIG_LO) |=> cfg_rdata == $past(sig_reg[31:0])
	) else $error("signature not readable");

	c_reg_edge: cover property (clk_edge && io_oe[0]);
	c_hold_seen: cover property (hold ##1 !hold);
	c_secured_sig: cover property (secure_reg && cfg_read && cfg_addr == ADDR_SIG_HI);

endmodule
`default_nettype wire

// file: tb/board_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// board logic facing the macrocell pins
// --------------------------------
module board_model
	import pld_pkg::*;
(
	// clock
	input  wire logic                 ref_clk,
	// device side
	input  wire logic [NUM_CELLS-1:0] io_out,
	input  wire logic [NUM_CELLS-1:0] io_oe,
	// board drivers
	input  wire logic [NUM_CELLS-1:0] drv_val,
	input  wire logic [NUM_CELLS-1:0] drv_en,
	// resolved pin level
	output logic      [NUM_CELLS-1:0] io_in
);
	logic [NUM_CELLS-1:0] keep_reg = '0; // weak keeper, last wire level

	// device driver wins, then board driver, else keeper holds the level
	always_comb begin
		io_in = (io_oe & io_out) | (~io_oe & drv_en & drv_val) | (~io_oe & ~drv_en & keep_reg);
	end

	// keeper follows the wire once it is known, so an unknown
	// level before reset does not stick on an undriven pin
	always @(posedge ref_clk) begin
		if (^io_in !== 1'bx) begin
			keep_reg <= io_in;
		end
	end
endmodule
`default_nettype wire

// file: tb/test_pld_array.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// self-checking bench for the logic array
// --------------------------------
module test_pld_array;
	import pld_pkg::*;
	logic                  ref_clk;   // system clock
	logic                  resetn;    // sync reset, active low
	logic [ADDR_WIDTH-1:0] cfg_addr;  // config word index
	logic [DATA_WIDTH-1:0] cfg_wdata; // config write data
	logic                  cfg_write; // write strobe
	logic                  cfg_read;  // read strobe
	logic [DATA_WIDTH-1:0] cfg_rdata; // read data
	logic                  clk_pin;   // pin 1 level
	logic                  oe_pin_n;  // pin 11 level
	logic [NUM_INPUTS-1:0] in_pins;   // pins 2..9
	logic [NUM_CELLS-1:0]  io_in;     // resolved cell pins
	logic [NUM_CELLS-1:0]  io_out;    // cell output values
	logic [NUM_CELLS-1:0]  io_oe;     // cell driver enables
	logic [NUM_CELLS-1:0]  drv_val;   // board drive value
	logic [NUM_CELLS-1:0]  drv_en;    // board drive enable
	logic [31:0]           d;         // read-back word
	int                    n_errors;  // mismatches
	int                    compares;  // comparisons
	logic [2:0]            v;         // table vector

	pld_array uut (.ref_clk(ref_clk), .resetn(resetn), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata), .clk_pin(clk_pin),
		.oe_pin_n(oe_pin_n), .in_pins(in_pins), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	board_model board (.ref_clk(ref_clk), .io_out(io_out), .io_oe(io_oe), .drv_val(drv_val),
		.drv_en(drv_en), .io_in(io_in));

	// clock at 100 MHz
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle config write
	task automatic wr(input logic [6:0] a, input logic [31:0] w);
		@(posedge ref_clk);
		cfg_write <= 1'b1;
		cfg_addr  <= a;
		cfg_wdata <= w;
		@(posedge ref_clk);
		cfg_write <= 1'b0;
	endtask

	// one-cycle config read, data in the following cycle
	task automatic rd(input logic [6:0] a);
		@(posedge ref_clk);
		cfg_read <= 1'b1;
		cfg_addr <= a;
		@(posedge ref_clk);
		cfg_read <= 1'b0;
		#1 d = cfg_rdata;
	endtask

	// drive pins, then wait for the registered outputs to follow
	task automatic apply(input logic c, input logic o, input logic [7:0] i, input logic [7:0] dv,
		input logic [7:0] de);
		@(posedge ref_clk);
		clk_pin  <= c;
		oe_pin_n <= o;
		in_pins  <= i;
		drv_val  <= dv;
		drv_en   <= de;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// power-up reset model
	task automatic do_reset;
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
	endtask

	// counts and verdict
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// reset state and unmapped read
	task automatic test_reset;
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (16) @(posedge ref_clk);
		#1;
		check(io_oe, 8'h00);
		check(io_out, 8'hff);
		@(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_ARCH);
		check(d, ARCH_RESET);
		rd(7'h45);
		check(d, 32'h0000_0000);
		$display("test reset done");
	endtask

	// registered mode: common clock, common enable, hold
	task automatic test_registered;
		do_reset;
		apply(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		wr(7'h00, 32'h0000_0001);
		wr(7'h08, 32'h0000_0002);
		wr(7'h09, 32'h0000_0008);
		wr(ADDR_ARCH, 32'hfff4_0000);
		apply(1'b0, 1'b0, 8'h01, 8'h00, 8'h00);
		check(io_out[0], 1'b1);
		apply(1'b1, 1'b0, 8'h01, 8'h00, 8'h00);
		check(io_out[0], 1'b0);
		check(io_oe[0], 1'b1);
		rd(ADDR_STATUS);
		check(d[0], 1'b1);
		apply(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
		check(io_out[0], 1'b0);
		apply(1'b1, 1'b1, 8'h02, 8'h00, 8'h00);
		check(io_oe[0], 1'b0);
		check(io_oe[1], 1'b1);
		check(io_out[1], 1'b0);
		apply(1'b1, 1'b0, 8'h0a, 8'h00, 8'h00);
		check(io_out[1], 1'b1);
		apply(1'b1, 1'b0, 8'h08, 8'h00, 8'h00);
		check(io_oe[1], 1'b0);
		check(io_oe[7:2], 6'h00);
		// hold option on, clock low before hold
		wr(ADDR_ARCH, 32'hfff4_0004);
		apply(1'b0, 1'b0, 8'h01, 8'h00, 8'h00);
		apply(1'b0, 1'b0, 8'h05, 8'h00, 8'h00);
		apply(1'b1, 1'b0, 8'h01, 8'h00, 8'h00);
		check(io_out[0], 1'b0);
		check(io_oe[0], 1'b1);
		rd(ADDR_STATUS);
		check(d[24], 1'b0);
		apply(1'b1, 1'b1, 8'h05, 8'h00, 8'h00);
		apply(1'b0, 1'b1, 8'h04, 8'h00, 8'h00);
		apply(1'b1, 1'b1, 8'h04, 8'h00, 8'h00);
		check(io_out[0], 1'b0);
		check(io_oe[0], 1'b1);
		rd(ADDR_STATUS);
		check(d[24], 1'b1);
		apply(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
		check(io_out[0], 1'b0);
		$display("test registered done");
	endtask

	// complex mode: pins 1 and 11 over outer paths, inner feedback
	task automatic test_complex;
		do_reset;
		wr(7'h18, 32'h0000_0000);
		wr(7'h19, 32'h0000_8000);
		wr(7'h1a, 32'h0000_1000);
		wr(7'h1b, 32'h0000_0100);
		wr(7'h00, 32'h0000_0000);
		wr(7'h01, 32'h0000_0000);
		wr(ADDR_ARCH, 32'hff7d_0001);
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 3'b000 : 3'b100 >> (k - 1);
			apply(v[2], v[1], 8'h00, {1'b1, 2'b00, v[0], 4'h0}, 8'h90);
			check(io_out[3], |v);
			check(io_oe[3], 1'b1);
		end
		check(io_oe[4], 1'b0);
		check({io_oe[0], io_out[0]}, 2'b11);
		$display("test complex done");
	endtask

	// simple mode: eight summed terms, cell 0 pin feedback, center cells on
	task automatic test_simple;
		do_reset;
		wr(7'h18, 32'h0000_0001);
		wr(7'h19, 32'h0000_8000);
		wr(7'h1a, 32'h0000_0200);
		wr(ADDR_ARCH, 32'hfffb_0002);
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 3'b000 : 3'b100 >> (k - 1);
			apply(v[1], 1'b0, {7'h00, v[2]}, {7'h00, v[0]}, 8'h01);
			check(io_out[3], |v);
		end
		check(io_oe, 8'h1a);
		check(io_out[4], 1'b0);
		$display("test simple done");
	endtask

	// signature stays readable once secured
	task automatic test_secure;
		do_reset;
		wr(ADDR_SIG_LO, 32'h5a5a_0f0f);
		wr(ADDR_SIG_HI, 32'hc3c3_1e1e);
		wr(ADDR_SECURE, 32'h0000_0001);
		wr(7'h45, 32'hffff_ffff);
		rd(ADDR_ARCH);
		check(d, 32'h0000_0000);
		rd(ADDR_SIG_LO);
		check(d, 32'h5a5a_0f0f);
		rd(ADDR_SIG_HI);
		check(d, 32'hc3c3_1e1e);
		rd(ADDR_STATUS);
		check(d[25], 1'b1);
		rd(7'h45);
		check(d, 32'h0000_0000);
		$display("test secure done");
	endtask

	// a hang counts as a mismatch
	initial begin
		#500000;
		n_errors++;
		end_of_test;
	end

	// main sequence
	initial begin
		n_errors  = 0;
		compares  = 0;
		resetn    = 1'b0;
		cfg_addr  = '0;
		cfg_wdata = '0;
		cfg_write = 1'b0;
		cfg_read  = 1'b0;
		clk_pin   = 1'b0;
		oe_pin_n  = 1'b0;
		in_pins   = '0;
		drv_val   = '0;
		drv_en    = '0;
		test_reset;
		test_registered;
		test_complex;
		test_simple;
		test_secure;
		end_of_test;
	end
endmodule
`default_nettype wire
